// file: hdl/sysctl_pkg.sv
// package for the system control coprocessor register file
// assumes a single core clock and synchronous active-high reset
package sysctl_pkg;

  // ---------------------------------------------------------------
  // register numbers
  // ---------------------------------------------------------------
  localparam logic [4:0] REG_USER_LOCAL  = 5'h04;
  localparam logic [4:0] REG_HWR_MASK    = 5'h07;
  localparam logic [4:0] REG_BAD_VADDR   = 5'h08;
  localparam logic [4:0] REG_CYCLE_COUNT = 5'h09;
  localparam logic [4:0] REG_TIMER_CMP   = 5'h0B;
  localparam logic [4:0] REG_STATUS      = 5'h0C;
  localparam logic [4:0] REG_CAUSE       = 5'h0D;
  localparam logic [4:0] REG_EPC         = 5'h0E;
  localparam logic [4:0] REG_PROCESSOR_IDENTIFICATION_BASE   = 5'h0F;
  localparam logic [4:0] REG_CONFIG      = 5'h10;
  localparam logic [4:0] REG_DEBUG       = 5'h17;
  localparam logic [4:0] REG_DEBUG_RETURN_PC        = 5'h18;
  localparam logic [4:0] REG_PERF        = 5'h19;
  localparam logic [4:0] REG_PARITY_CTL  = 5'h1A;
  localparam logic [4:0] REG_PARITY_ERR  = 5'h1B;
  localparam logic [4:0] REG_ERROR_EPC   = 5'h1E;
  localparam logic [4:0] REG_DEBUG_SCR   = 5'h1F;

  // hardware register read selector for the user local word
  localparam logic [4:0] HWR_USER_LOCAL  = 5'h1D;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int STATUS_IE_BIT   = 0;
  localparam int STATUS_EXL_BIT  = 1;
  localparam int STATUS_ERL_BIT  = 2;
  localparam int STATUS_UM_BIT   = 4;
  localparam int CAUSE_TI_BIT    = 30;
  localparam int PERF_CTL_EN_BIT = 0;
  localparam int PARITY_EN_BIT   = 31;
  localparam int PARITY_ERR_BIT  = 31;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] STATUS_RESET  = 32'h0040_0004;
  localparam logic [31:0] EXCEPTION_VECTOR_BASE_RESET   = 32'h8000_0000;
  localparam logic [31:0] CONFIG0_VALUE = 32'hA480_0483;
  localparam logic [31:0] CONFIG1_VALUE = 32'h8000_0012;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_KERNEL = 2'b00,
    MODE_USER   = 2'b01,
    MODE_DEBUG  = 2'b11
  } op_mode_t;

  typedef enum logic [1:0] {
    PWR_RUN     = 2'b00,
    PWR_DOWN    = 2'b01
  } pwr_state_t;

  typedef struct packed {
    logic        rd_en;
    logic        wr_en;
    logic [4:0]  num;
    logic [2:0]  sel;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        valid;
    logic        addr_err;
    logic [4:0]  code;
    logic [31:0] pc;
    logic [31:0] bad_addr;
    logic        in_delay;
  } exc_evt_t;

endpackage

// file: hdl/sysctl_regs.sv
// system control coprocessor register file with power-down entry
// assumes the pipeline issues one register move per cycle
//
// Function
// - number 4 holds writable user word, readable at hw selector 29.
// - number 7 masks hw registers readable in user mode.
// - number 8 captures address of latest address-related exception.
// - number 12 holds status, interrupt and shadow control, modes, IE.
// - number 13 records cause of latest exception.
// - number 14 loads pc of last ordinary exception taken with EXL clear.
// - number 24 holds debug return pc and second user trace word.
// - number 30 loads pc of last error, separate from others.
// - number 25 gives two counters each with own control register.
// - number 26 holds parity checking enable.
// - number 27 records detected memory parity error details.
// - number 31 is a free debug scratchpad.
// - number 23 holds debug, debug2, trace controls, trace data, bp.
// - numbers 0-3, 5-6 and 10 are reserved, read zero.
// - number 15 gives id, vector base and device map base.
// - wait instruction enters power-down mode.
// - fully static logic; clock may slow or stop.
// - registers update only when enabled, except cause bit 30 (copies timer flag each cycle) and count (runs unless debug bit 25 set); allows clock gating.
`timescale 1ns/1ps
`default_nettype none

module sysctl_regs #(
  parameter logic [31:0] PROC_ID       = 32'h0001_2345, // arbitrary
  parameter logic [31:0] DEV_MAP_BASE  = 32'h0000_0000
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // register moves
  input  wire sysctl_pkg::reg_req_t req,
  output logic [31:0]             rdata,
  // hardware register read
  input  wire logic               hwr_en,
  input  wire logic [4:0]         hwr_sel,
  output logic [31:0]             hwr_data,
  output logic                    hwr_denied,
  // exception events
  input  wire sysctl_pkg::exc_evt_t exc,
  input  wire logic               dbg_exc,
  input  wire logic [31:0]        dbg_pc,
  input  wire logic               err_exc,
  input  wire logic [31:0]        err_pc,
  input  wire logic               eret,
  input  wire logic               deret,
  // performance events
  input  wire logic [1:0]         perf_evt,
  // memory parity
  input  wire logic               parity_err,
  input  wire logic               parity_err_data,
  input  wire logic [29:0]        parity_err_addr,
  output logic                    parity_check_en,
  // power
  input  wire logic               wait_exec,
  input  wire logic               wake,
  output logic                    power_down,
  // status outputs
  output sysctl_pkg::op_mode_t    mode,
  output logic                    int_enable,
  output logic                    timer_irq
);
  import sysctl_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [31:0] user_local_q, hwr_mask_q, bad_vaddr_q, count_q, compare_q;
  logic [31:0] status_q, interrupt_control_q, shadow_set_control_q, cause_q, epc_q, exception_vector_base_q;
  logic [31:0] debug_q, debug2_q, trace_ctl_q, trace_ctl2_q;
  logic [31:0] trace_word1_q, trace_bpc_q, debug_return_pc_q, trace_word2_q;
  logic [31:0] perf_ctl_q [2];
  logic [31:0] perf_cnt_q [2];
  logic [31:0] parity_ctl_q, parity_err_q, error_epc_q, debug_scr_q;
  logic        dbg_mode_q;
  pwr_state_t  pwr_q;
  logic        ti_q;

  logic wr;
  assign wr = req.wr_en;

  function automatic logic hit(input logic [4:0] n, input logic [2:0] s);
    hit = wr && req.num == n && req.sel == s;
  endfunction

  // ---------------------------------------------------------------
  // plain software registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      user_local_q <= ZERO_WORD;
      hwr_mask_q   <= ZERO_WORD;
      debug_scr_q  <= ZERO_WORD;
      parity_ctl_q <= ZERO_WORD;
      compare_q    <= ZERO_WORD;
    end else begin
      if (hit(REG_USER_LOCAL, 3'h0)) begin
        user_local_q <= req.wdata;
      end
      if (hit(REG_HWR_MASK, 3'h0)) begin
        hwr_mask_q <= req.wdata;
      end
      if (hit(REG_DEBUG_SCR, 3'h0)) begin
        debug_scr_q <= req.wdata;
      end
      if (hit(REG_PARITY_CTL, 3'h0)) begin
        parity_ctl_q <= req.wdata;
      end
      if (hit(REG_TIMER_CMP, 3'h0)) begin
        compare_q <= req.wdata;
      end
    end
  end

  assign parity_check_en = parity_ctl_q[PARITY_EN_BIT];

  // ---------------------------------------------------------------
  // hardware register read path
  // ---------------------------------------------------------------
  always_comb begin
    hwr_data   = ZERO_WORD;
    hwr_denied = 1'b0;
    if (hwr_en) begin
      if (mode == MODE_USER && !hwr_mask_q[hwr_sel]) begin
        hwr_denied = 1'b1;
      end else if (hwr_sel == HWR_USER_LOCAL) begin
        hwr_data = user_local_q;
      end else if (hwr_sel == 5'h02) begin
        hwr_data = count_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // timer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= ZERO_WORD;
    end else if (hit(REG_CYCLE_COUNT, 3'h0)) begin
      count_q <= req.wdata;
    end else if (!debug_q[25]) begin
      count_q <= count_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ti_q <= 1'b0;
    end else if (count_q == compare_q) begin
      ti_q <= 1'b1; // set wins over clear
    end else if (hit(REG_TIMER_CMP, 3'h0)) begin
      ti_q <= 1'b0;
    end
  end

  assign timer_irq = ti_q;

  // ---------------------------------------------------------------
  // status, interrupt and shadow control
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= STATUS_RESET;
      interrupt_control_q <= ZERO_WORD;
      shadow_set_control_q <= ZERO_WORD;
    end else begin
      if (err_exc) begin
        status_q[STATUS_ERL_BIT] <= 1'b1;
      end else if (exc.valid) begin
        status_q[STATUS_EXL_BIT] <= 1'b1;
      end else if (eret) begin
        if (status_q[STATUS_ERL_BIT]) begin
          status_q[STATUS_ERL_BIT] <= 1'b0;
        end else begin
          status_q[STATUS_EXL_BIT] <= 1'b0;
        end
      end else if (hit(REG_STATUS, 3'h0)) begin
        status_q <= req.wdata;
      end
      if (hit(REG_STATUS, 3'h1)) begin
        interrupt_control_q <= req.wdata;
      end
      if (hit(REG_STATUS, 3'h2)) begin
        shadow_set_control_q <= req.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dbg_mode_q <= 1'b0;
    end else if (dbg_exc) begin
      dbg_mode_q <= 1'b1;
    end else if (deret) begin
      dbg_mode_q <= 1'b0;
    end
  end

  always_comb begin
    if (dbg_mode_q) begin
      mode = MODE_DEBUG;
    end else if (status_q[STATUS_UM_BIT] && !status_q[STATUS_EXL_BIT]
                 && !status_q[STATUS_ERL_BIT]) begin
      mode = MODE_USER;
    end else begin
      mode = MODE_KERNEL;
    end
  end

  assign int_enable = status_q[STATUS_IE_BIT] && !status_q[STATUS_EXL_BIT]
                      && !status_q[STATUS_ERL_BIT] && !dbg_mode_q;

  // ---------------------------------------------------------------
  // exception capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      bad_vaddr_q <= ZERO_WORD;
    end else if (exc.valid && exc.addr_err) begin
      bad_vaddr_q <= exc.bad_addr;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cause_q <= ZERO_WORD;
    end else begin
      if (exc.valid) begin
        cause_q[31]  <= exc.in_delay;
        cause_q[6:2] <= exc.code;
      end else if (hit(REG_CAUSE, 3'h0)) begin
        cause_q[9:8] <= req.wdata[9:8];
      end
      cause_q[CAUSE_TI_BIT] <= ti_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      epc_q <= ZERO_WORD;
    end else if (exc.valid && !status_q[STATUS_EXL_BIT]) begin
      epc_q <= exc.pc;
    end else if (hit(REG_EPC, 3'h0)) begin
      epc_q <= req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      error_epc_q <= ZERO_WORD;
    end else if (err_exc) begin
      error_epc_q <= err_pc;
    end else if (hit(REG_ERROR_EPC, 3'h0)) begin
      error_epc_q <= req.wdata;
    end
  end

  // ---------------------------------------------------------------
  // vector base
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      exception_vector_base_q <= EXCEPTION_VECTOR_BASE_RESET;
    end else if (hit(REG_PROCESSOR_IDENTIFICATION_BASE, 3'h1)) begin
      exception_vector_base_q[29:12] <= req.wdata[29:12];
    end
  end

  // ---------------------------------------------------------------
  // debug and trace
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      debug_q       <= ZERO_WORD;
      debug2_q      <= ZERO_WORD;
      trace_ctl_q   <= ZERO_WORD;
      trace_ctl2_q  <= ZERO_WORD;
      trace_word1_q <= ZERO_WORD;
      trace_bpc_q   <= ZERO_WORD;
      trace_word2_q <= ZERO_WORD;
    end else begin
      if (hit(REG_DEBUG, 3'h0)) begin
        debug_q <= req.wdata;
      end
      if (hit(REG_DEBUG, 3'h6)) begin
        debug2_q <= req.wdata;
      end
      if (hit(REG_DEBUG, 3'h1)) begin
        trace_ctl_q <= req.wdata;
      end
      if (hit(REG_DEBUG, 3'h2)) begin
        trace_ctl2_q <= req.wdata;
      end
      if (hit(REG_DEBUG, 3'h3)) begin
        trace_word1_q <= req.wdata;
      end
      if (hit(REG_DEBUG, 3'h4)) begin
        trace_bpc_q <= req.wdata;
      end
      if (hit(REG_DEBUG_RETURN_PC, 3'h1)) begin
        trace_word2_q <= req.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      debug_return_pc_q <= ZERO_WORD;
    end else if (dbg_exc) begin
      debug_return_pc_q <= dbg_pc;
    end else if (hit(REG_DEBUG_RETURN_PC, 3'h0)) begin
      debug_return_pc_q <= req.wdata;
    end
  end

  // ---------------------------------------------------------------
  // performance counters
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_perf
    always_ff @(posedge clk) begin
      if (rst) begin
        perf_ctl_q[i] <= ZERO_WORD;
        perf_cnt_q[i] <= ZERO_WORD;
      end else begin
        if (hit(REG_PERF, 3'(2 * i))) begin
          perf_ctl_q[i] <= req.wdata;
        end
        if (hit(REG_PERF, 3'(2 * i + 1))) begin
          perf_cnt_q[i] <= req.wdata;
        end else if (perf_ctl_q[i][PERF_CTL_EN_BIT] && perf_evt[i]) begin
          perf_cnt_q[i] <= perf_cnt_q[i] + 32'h0000_0001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // parity error record
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      parity_err_q <= ZERO_WORD;
    end else if (parity_err && parity_check_en) begin
      parity_err_q <= {1'b1, parity_err_data, parity_err_addr};
    end else if (hit(REG_PARITY_ERR, 3'h0)) begin
      parity_err_q[PARITY_ERR_BIT] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // power down
  // ---------------------------------------------------------------
  // all state in plain flops; no dynamic nodes
  always_ff @(posedge clk) begin
    if (rst) begin
      pwr_q <= PWR_RUN;
    end else begin
      unique case (pwr_q)
        PWR_RUN: begin
          if (wait_exec) begin
            pwr_q <= PWR_DOWN;
          end
        end
        PWR_DOWN: begin
          if (wake || ti_q) begin
            pwr_q <= PWR_RUN;
          end
        end
        default: pwr_q <= PWR_RUN;
      endcase
    end
  end

  assign power_down = (pwr_q == PWR_DOWN); // gate enable

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rdata = ZERO_WORD;
    if (req.rd_en) begin
      unique case (req.num)
        REG_USER_LOCAL:  rdata = user_local_q;
        REG_HWR_MASK:    rdata = hwr_mask_q;
        REG_BAD_VADDR:   rdata = bad_vaddr_q;
        REG_CYCLE_COUNT: rdata = count_q;
        REG_TIMER_CMP:   rdata = compare_q;
        REG_STATUS: begin
          if (req.sel == 3'h1) begin
            rdata = interrupt_control_q;
          end else if (req.sel == 3'h2) begin
            rdata = shadow_set_control_q;
          end else if (req.sel == 3'h0) begin
            rdata = status_q;
          end
        end
        REG_CAUSE: rdata = cause_q;
        REG_EPC:   rdata = epc_q;
        REG_PROCESSOR_IDENTIFICATION_BASE: begin
          if (req.sel == 3'h0) begin
            rdata = PROC_ID;
          end else if (req.sel == 3'h1) begin
            rdata = exception_vector_base_q;
          end else if (req.sel == 3'h2) begin
            rdata = DEV_MAP_BASE;
          end
        end
        REG_CONFIG: begin
          if (req.sel == 3'h0) begin
            rdata = CONFIG0_VALUE;
          end else if (req.sel == 3'h1) begin
            rdata = CONFIG1_VALUE;
          end
        end
        REG_DEBUG: begin
          unique case (req.sel)
            3'h0: rdata = {debug_q[31:1], dbg_mode_q};
            3'h1: rdata = trace_ctl_q;
            3'h2: rdata = trace_ctl2_q;
            3'h3: rdata = trace_word1_q;
            3'h4: rdata = trace_bpc_q;
            3'h6: rdata = debug2_q;
            default: rdata = ZERO_WORD;
          endcase
        end
        REG_DEBUG_RETURN_PC: rdata = (req.sel == 3'h1) ? trace_word2_q : debug_return_pc_q;
        REG_PERF: begin
          if (req.sel[2:1] == 2'b00) begin
            rdata = req.sel[0] ? perf_cnt_q[0] : perf_ctl_q[0];
          end else if (req.sel[2:1] == 2'b01) begin
            rdata = req.sel[0] ? perf_cnt_q[1] : perf_ctl_q[1];
          end
        end
        REG_PARITY_CTL: rdata = parity_ctl_q;
        REG_PARITY_ERR: rdata = parity_err_q;
        REG_ERROR_EPC:  rdata = error_epc_q;
        REG_DEBUG_SCR:  rdata = debug_scr_q;
        default:        rdata = ZERO_WORD;
      endcase
    end
  end

endmodule

`default_nettype wire

// file: tb/sysctl_regs_assertions.sv
// checker for the coprocessor register file
// bound to sysctl_regs, sees only its ports
`timescale 1ns/1ps
`default_nettype none
module sysctl_regs_assertions
  import sysctl_pkg::*;
(
  // clock and reset
  input wire logic                 clk,
  input wire logic                 rst,
  // moves and hw reads
  input wire sysctl_pkg::reg_req_t req,
  input wire logic [31:0]          rdata,
  input wire logic                 hwr_en,
  input wire logic [4:0]           hwr_sel,
  input wire logic [31:0]          hwr_data,
  // events
  input wire sysctl_pkg::exc_evt_t exc,
  input wire logic                 dbg_exc,
  input wire logic [31:0]          dbg_pc,
  input wire logic                 err_exc,
  input wire logic [31:0]          err_pc,
  input wire logic                 eret,
  input wire logic                 deret,
  input wire logic                 wait_exec,
  input wire logic                 wake,
  // status
  input wire logic                 power_down,
  input wire logic                 parity_check_en,
  input wire sysctl_pkg::op_mode_t mode,
  input wire logic                 int_enable,
  input wire logic                 timer_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // assertions
  // ----
  user_word_a: assert property (req.wr_en && req.num == REG_USER_LOCAL
    && req.sel == 3'h0 ##1 hwr_en && hwr_sel == HWR_USER_LOCAL
    && mode != MODE_USER |-> hwr_data == $past(req.wdata))
    else $error("user word lost");
  reserved_zero_a: assert property (req.rd_en && (req.num < 5'h04
    || req.num inside {5'h05, 5'h06, 5'h0A}) |-> rdata == 32'h0)
    else $error("reserved number reads nonzero");
  bad_addr_a: assert property (exc.valid && exc.addr_err ##1 req.rd_en
    && req.num == REG_BAD_VADDR && req.sel == 3'h0
    |-> rdata == $past(exc.bad_addr)) else $error("bad address not held");
  error_pc_a: assert property (err_exc ##1 req.rd_en
    && req.num == REG_ERROR_EPC && req.sel == 3'h0
    |-> rdata == $past(err_pc)) else $error("error pc not loaded");
  debug_pc_a: assert property (dbg_exc ##1 req.rd_en
    && req.num == REG_DEBUG_RETURN_PC && req.sel == 3'h0
    |-> rdata == $past(dbg_pc)) else $error("debug pc not loaded");
  sleep_entry_a: assert property (wait_exec && !wake && !timer_irq
    |=> power_down) else $error("wait did not power down");
  sleep_hold_a: assert property (power_down && !wake && !timer_irq
    |=> power_down) else $error("power down dropped alone");
  wake_exit_a: assert property (power_down && wake && !wait_exec
    |=> !power_down) else $error("wake ignored");
  irq_mode_a: assert property (int_enable |-> mode != MODE_DEBUG)
    else $error("interrupts on in debug mode");
  exc_mask_a: assert property (exc.valid && !eret && !deret
    |=> !int_enable) else $error("interrupts on after exception");
  timer_hold_a: assert property (timer_irq && !(req.wr_en
    && req.num == REG_TIMER_CMP) |=> timer_irq) else $error("irq not sticky");
  parity_en_a: assert property (req.wr_en && req.num == REG_PARITY_CTL
    && req.sel == 3'h0 |=> parity_check_en == $past(req.wdata[31]))
    else $error("parity enable not written");
  sleep_c: cover property ($rose(power_down));
  timer_c: cover property ($rose(timer_irq));
  exc_c: cover property (exc.valid && exc.addr_err);
endmodule
bind sysctl_regs sysctl_regs_assertions chk (
  .clk, .rst, .req, .rdata, .hwr_en, .hwr_sel, .hwr_data, .exc, .dbg_exc,
  .dbg_pc, .err_exc, .err_pc, .eret, .deret, .wait_exec, .wake,
  .power_down, .parity_check_en, .mode, .int_enable, .timer_irq
);
`default_nettype wire

// file: tb/pipe_model.sv
// pipeline side: issues coprocessor moves and hw register reads
// assumes bench calls its tasks; drives on falling edges
`timescale 1ns/1ps
`default_nettype none
module pipe_model
  import sysctl_pkg::*;
(
  // clock
  input  wire logic            clk,
  // register moves
  output sysctl_pkg::reg_req_t req,
  input  wire logic [31:0]     rdata,
  // hardware register read
  output logic                 hwr_en,
  output logic [4:0]           hwr_sel,
  input  wire logic [31:0]     hwr_data,
  input  wire logic            hwr_denied
);
  initial begin
    req = '0;
    hwr_en = 1'b0;
    hwr_sel = 5'h00;
  end
  // one move held across one rising edge; idle data toggles
  task automatic move(input logic wr, input logic [4:0] num,
                      input logic [2:0] sel, input logic [31:0] d,
                      output logic [31:0] q);
    @(negedge clk);
    req = '{~wr, wr, num, sel, wr ? d : ~req.wdata};
    #10 q = rdata;
    @(negedge clk);
    req.rd_en = 1'b0;
    req.wr_en = 1'b0;
    req.wdata = ~req.wdata;
  endtask
  task automatic hwr(input logic [4:0] s, output logic [31:0] q,
                     output logic den);
    @(negedge clk);
    hwr_en = 1'b1;
    hwr_sel = s;
    #10 q = hwr_data;
    den = hwr_denied;
    @(negedge clk);
    hwr_en = 1'b0;
    hwr_sel = ~s;
  endtask
endmodule
`default_nettype wire

// file: tb/system_coprocessor_registers_tb_top.sv
// bench for the coprocessor register file
// assumes pipe_model as far side and the bound checker
`timescale 1ns/1ps
`default_nettype none
module system_coprocessor_registers_tb_top;
  import sysctl_pkg::*;
  localparam logic [31:0] ID = 32'h0000_0ABC; // arbitrary
  logic        clk, rst, hwr_en, hwr_denied, dbg_exc, err_exc, eret, deret;
  logic        parity_err, parity_err_data, parity_check_en, wait_exec;
  logic        wake, power_down, int_enable, timer_irq;
  logic [4:0]  hwr_sel;
  logic [1:0]  perf_evt;
  logic [29:0] parity_err_addr;
  logic [31:0] rdata, hwr_data, dbg_pc, err_pc, q;
  reg_req_t    req;
  exc_evt_t    exc;
  op_mode_t    mode;
  int          fails, n_tests;
  sysctl_regs #(.PROC_ID(ID)) dut (.clk, .rst, .req, .rdata, .hwr_en,
    .hwr_sel, .hwr_data, .hwr_denied, .exc, .dbg_exc, .dbg_pc, .err_exc,
    .err_pc, .eret, .deret, .perf_evt, .parity_err, .parity_err_data,
    .parity_err_addr, .parity_check_en, .wait_exec, .wake, .power_down,
    .mode, .int_enable, .timer_irq);
  pipe_model pipe (.clk, .req, .rdata, .hwr_en, .hwr_sel, .hwr_data,
    .hwr_denied);
  // ----
  // helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] n, input logic [2:0] s,
                    input logic [31:0] d);
    pipe.move(1'b1, n, s, d, q);
  endtask
  task automatic rdc(input logic [4:0] n, input logic [2:0] s,
                     input logic [31:0] exp);
    pipe.move(1'b0, n, s, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic pulse(ref logic sig);
    @(negedge clk);
    sig = 1'b1;
    @(negedge clk);
    sig = 1'b0;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic s_reset();
    rdc(REG_STATUS, 3'h0, STATUS_RESET);
    rdc(REG_PROCESSOR_IDENTIFICATION_BASE, 3'h0, ID);
    rdc(REG_PROCESSOR_IDENTIFICATION_BASE, 3'h1, EXCEPTION_VECTOR_BASE_RESET);
    rdc(REG_CONFIG, 3'h0, CONFIG0_VALUE);
    rdc(REG_CONFIG, 3'h1, CONFIG1_VALUE);
    chk(32'(mode), 32'(MODE_KERNEL));
  endtask
  task automatic s_reserved();
    logic [4:0] n[10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h0A,
                          5'h11, 5'h1C, REG_BAD_VADDR};
    foreach (n[i]) begin
      wr(n[i], 3'h0, 32'hFFFF_FFFF);
      rdc(n[i], 3'h0, 32'h0);
    end
  endtask
  task automatic s_rw();
    logic [4:0] n[8] = '{REG_USER_LOCAL, REG_HWR_MASK, REG_EPC, REG_DEBUG_RETURN_PC,
                         REG_ERROR_EPC, REG_DEBUG_SCR, REG_PERF, REG_PERF};
    logic [2:0] s[8] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h0, 3'h0, 3'h0, 3'h2};
    foreach (n[i]) wr(n[i], s[i], {24'h5AC300, 3'(i), n[i]});
    foreach (n[i])
      rdc(n[i], s[i], {24'h5AC300, 3'(i), n[i]});
  endtask
  task automatic s_hwr();
    logic d;
    fork
      wr(REG_USER_LOCAL, 3'h0, 32'h1234_5678);
      begin
        @(negedge clk);
        pipe.hwr(HWR_USER_LOCAL, q, d);
      end
    join
    chk(q, 32'h1234_5678);
    wr(REG_HWR_MASK, 3'h0, 32'h0);
    wr(REG_STATUS, 3'h0, 32'h0000_0011);
    chk(32'(mode), 32'(MODE_USER));
    chk(32'(int_enable), 32'h1);
    pipe.hwr(HWR_USER_LOCAL, q, d);
    chk(32'(d), 32'h1);
    wr(REG_HWR_MASK, 3'h0, 32'h2000_0000);
    pipe.hwr(HWR_USER_LOCAL, q, d);
    chk(32'(d), 32'h0);
    wr(REG_STATUS, 3'h0, 32'h0000_0001);
  endtask
  task automatic s_exc();
    exc = '{1'b1, 1'b1, 5'h05, 32'h0000_4A10, 32'h0BAD_0004, 1'b1};
    fork
      begin
        @(negedge clk);
        exc.valid = 1'b0;
      end
      rdc(REG_BAD_VADDR, 3'h0, 32'h0BAD_0004);
    join
    chk(32'(int_enable), 32'h0);
    rdc(REG_EPC, 3'h0, 32'h0000_4A10);
    pipe.move(1'b0, REG_CAUSE, 3'h0, 32'h0, q);
    chk(32'({q[31], q[6:2]}), 32'h25);
    pulse(eret);
    chk(32'(int_enable), 32'h1);
    dbg_pc = 32'h0000_7F00;
    fork
      pulse(dbg_exc);
      begin
        @(negedge clk);
        rdc(REG_DEBUG_RETURN_PC, 3'h0, 32'h0000_7F00);
      end
    join
    chk(32'(mode), 32'(MODE_DEBUG));
    pulse(deret);
    chk(32'(mode), 32'(MODE_KERNEL));
    err_pc = 32'h0000_9C04;
    fork
      pulse(err_exc);
      begin
        @(negedge clk);
        rdc(REG_ERROR_EPC, 3'h0, 32'h0000_9C04);
      end
    join
    rdc(REG_EPC, 3'h0, 32'h0000_4A10);
    pulse(eret);
  endtask
  task automatic s_timer();
    int k;
    wr(REG_CYCLE_COUNT, 3'h0, 32'h0);
    wr(REG_TIMER_CMP, 3'h0, 32'h0000_0028);
    chk(32'(timer_irq), 32'h0);
    for (k = 0; k < 80 && timer_irq !== 1'b1; k++) @(negedge clk);
    if (k == 80) begin
      fails++;
      $display("BAD %0t timer never fired", $time);
      wrap_up();
    end
    chk(32'(k >= 35 && k <= 42), 32'h1);
    pipe.move(1'b0, REG_CAUSE, 3'h0, 32'h0, q);
    chk(32'(q[CAUSE_TI_BIT]), 32'h1);
    wr(REG_TIMER_CMP, 3'h0, 32'hFFFF_0000);
    chk(32'(timer_irq), 32'h0);
  endtask
  task automatic s_power();
    pulse(wait_exec);
    chk(32'(power_down), 32'h1);
    repeat (5) @(negedge clk);
    chk(32'(power_down), 32'h1);
    pulse(wake);
    chk(32'(power_down), 32'h0);
  endtask
  task automatic s_parity_perf();
    wr(REG_PARITY_CTL, 3'h0, 32'h8000_0000);
    chk(32'(parity_check_en), 32'h1);
    parity_err_data = 1'b1;
    parity_err_addr = 30'h0ABC_1234;
    pulse(parity_err);
    rdc(REG_PARITY_ERR, 3'h0, {2'b11, 30'h0ABC_1234});
    wr(REG_PERF, 3'h0, 32'h1);
    wr(REG_PERF, 3'h1, 32'h0);
    wr(REG_PERF, 3'h3, 32'h0);
    perf_evt = 2'b01;
    repeat (3) @(negedge clk);
    perf_evt = 2'b00;
    rdc(REG_PERF, 3'h1, 32'h3);
    rdc(REG_PERF, 3'h3, 32'h0);
  endtask
  // ----
  // run
  // ----
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {dbg_exc, err_exc, eret, deret, parity_err, parity_err_data} = '0;
    {wait_exec, wake, perf_evt, parity_err_addr, dbg_pc, err_pc} = '0;
    exc = '0;
    fails = 0;
    n_tests = 0;
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    s_reset();
    s_reserved();
    s_rw();
    s_hwr();
    s_exc();
    s_timer();
    s_power();
    s_parity_perf();
    wrap_up();
  end
endmodule
`default_nettype wire
